// ---- rtl/interrupt_sequencing_pin_irq.sv ----
// Interrupt qualification, entry and return sequencer with external pin and low-voltage sources.
// ==========================================================================
// Summary of operation
// - All registers run on the bus clock.
// - Source events set read-only status flags; peripheral ones even when disabled.
// - Request needs flag and local enable both.
// - Reset sets global mask; cleared mask accepts.
// - Entry starts only at instruction boundary.
// - Entry stacks, masks, fetches vector, fills three.
// - Hardware entry equals software trap sequence.
// - Stack order PROGRAM_COUNTER_LOW, PROGRAM_COUNTER_HIGH, X, A, CONDITION_CODE_REGISTER.
// - Upper index register never saved automatically.
// - Return reloads CONDITION_CODE_REGISTER, A, X, PC.
// - Clearing mask in handler allows nesting.
// - Highest priority pending source served first.
// - Vector high byte first, low byte next.
// - Pullup on while enabled and disable clear.
// - Pin level readable for branch instructions.
// - Level mode holds flag while pin asserted.
// - Low-voltage flag needs DE, IE, not RE.
// - Low-voltage warning never raises a request.
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "irq_seq_defs.svh"

module interrupt_sequencing_pin_irq
	import irq_seq_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        pin_irq_n_i,
	input  wire logic        lv_detect_i,
	input  wire logic        lv_warning_i,
	input  wire logic [3:0]  periph_event_i,
	input  wire logic        boundary_i,
	input  wire logic        swi_i,
	input  wire logic        rti_i,
	input  wire core_regs_t  core_i,
	input  wire logic [7:0]  mem_rdata_i,
	output mem_req_t         mem_o,
	output core_regs_t       regs_o,
	output logic      [23:0] queue_o,
	output logic             done_o,
	output logic             ret_done_o,
	output logic             busy_o,
	output logic      [7:0]  ccr_o,
	output logic             pullup_en_o,
	output logic             pin_level_o
);

	// ======================================================================
	// Helper functions
	function automatic logic [2:0] prio_pick(input logic [5:0] p);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (p[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : prio_pick

	function automatic logic [15:0] vec_of(input logic [2:0] idx);
		return `VEC_SRC_TOP - {12'h000, idx, 1'b0};
	endfunction : vec_of

	// ======================================================================
	// Pin and supply synchronisers
	// A change counts only when the second and third stages agree, so a
	// metastable first stage can never produce a double edge.
	logic [2:0] pin_s_r;
	logic [2:0] lvd_s_r;
	logic [2:0] lvw_s_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s_r <= 3'h7;
			lvd_s_r <= 3'h0;
			lvw_s_r <= 3'h0;
		end else begin
			pin_s_r <= {pin_s_r[1:0], pin_irq_n_i};
			lvd_s_r <= {lvd_s_r[1:0], lv_detect_i};
			lvw_s_r <= {lvw_s_r[1:0], lv_warning_i};
		end
	end

	// ======================================================================
	// Configuration, flags and bus slave
	logic       wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0] pin_ctl_r, pin_ctl_nxt;
	logic [2:0] lv_ctl_r, lv_ctl_nxt;
	logic [3:0] src_en_r, src_en_nxt;
	logic [3:0] src_flag_r, src_flag_nxt;
	logic       pin_flag_r, pin_flag_nxt;
	logic       lv_flag_r, lv_flag_nxt;
	logic       pin_high_r, pin_high_nxt;
	logic       lv_lvl_r, lv_lvl_nxt;
	logic       lvw_lvl_r, lvw_lvl_nxt;
	logic       pullup_r, pullup_nxt;
	logic       wr_go;
	logic       ccr_wr;
	logic       pin_edge;
	logic [5:0] pend;
	seq_state_t state_r, state_nxt;
	logic [7:0] ccr_r, ccr_nxt;

	assign wr_go    = avs_write_i && !wait_r && avs_byteenable_i[0];
	assign ccr_wr   = wr_go && (avs_address_i == `OFS_CCR);
	assign pend     = {src_flag_r & src_en_r,
	                   pin_flag_r & pin_ctl_r[`PIN_IE_BIT],
	                   lv_flag_r & lv_ctl_r[`LV_IE_BIT]};

	always_comb begin
		wait_nxt     = !((avs_read_i || avs_write_i) && wait_r);
		rdata_nxt    = rdata_r;
		pin_ctl_nxt  = pin_ctl_r;
		lv_ctl_nxt   = lv_ctl_r;
		src_en_nxt   = src_en_r;
		src_flag_nxt = src_flag_r;
		pin_flag_nxt = pin_flag_r;
		lv_flag_nxt  = lv_flag_r;
		pin_high_nxt = (pin_s_r[1] == pin_s_r[2]) ? pin_s_r[2] : pin_high_r;
		lv_lvl_nxt   = (lvd_s_r[1] == lvd_s_r[2]) ? lvd_s_r[2] : lv_lvl_r;
		lvw_lvl_nxt  = (lvw_s_r[1] == lvw_s_r[2]) ? lvw_s_r[2] : lvw_lvl_r;
		pin_edge     = pin_high_r && !pin_high_nxt;
		if (avs_read_i && wait_r) begin
			unique case (avs_address_i)
				`OFS_PIN_CTRL: rdata_nxt = {25'h0, pin_high_r, 1'b0, pin_flag_r, pin_ctl_r};
				`OFS_LV_CTRL:  rdata_nxt = {26'h0, lvw_lvl_r, 1'b0, lv_flag_r, lv_ctl_r};
				`OFS_SRC_EN:   rdata_nxt = {28'h0, src_en_r};
				`OFS_SRC_FLAG: rdata_nxt = {28'h0, src_flag_r};
				`OFS_CCR:      rdata_nxt = {24'h0, ccr_r};
				`OFS_STATUS:   rdata_nxt = {25'h0, |pend, prio_pick(pend), state_r};
				default:       rdata_nxt = 32'h0;
			endcase
		end
		if (wr_go) begin
			unique case (avs_address_i)
				`OFS_PIN_CTRL: begin
					pin_ctl_nxt = avs_writedata_i[3:0];
					if (avs_writedata_i[`PIN_ACK_BIT]) begin
						pin_flag_nxt = 1'b0;
					end
				end
				`OFS_LV_CTRL: begin
					lv_ctl_nxt = avs_writedata_i[2:0];
					if (avs_writedata_i[`LV_ACK_BIT]) begin
						lv_flag_nxt = 1'b0;
					end
				end
				`OFS_SRC_EN:   src_en_nxt = avs_writedata_i[3:0];
				`OFS_SRC_FLAG: src_flag_nxt = src_flag_r & ~avs_writedata_i[3:0];
				default: ;
			endcase
		end
		// Hardware sets win over a clear in the same cycle.
		src_flag_nxt = src_flag_nxt | periph_event_i;
		if (pin_ctl_r[`PIN_EN_BIT] && pin_edge) begin
			pin_flag_nxt = 1'b1;
		end
		if (pin_ctl_r[`PIN_EN_BIT] && pin_ctl_r[`PIN_MODE_BIT] && !pin_high_r) begin
			pin_flag_nxt = 1'b1;
		end
		if (lv_lvl_r && lv_ctl_r[`LV_DE_BIT] && lv_ctl_r[`LV_IE_BIT] && !lv_ctl_r[`LV_RE_BIT]) begin
			lv_flag_nxt = 1'b1;
		end
		pullup_nxt = pin_ctl_r[`PIN_EN_BIT] && !pin_ctl_r[`PIN_PDD_BIT];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_r     <= 1'b1;
			rdata_r    <= 32'h0;
			pin_ctl_r  <= `CTRL_RST;
			lv_ctl_r   <= 3'h0;
			src_en_r   <= `SRC_EN_RST;
			src_flag_r <= 4'h0;
			pin_flag_r <= 1'b0;
			lv_flag_r  <= 1'b0;
			pin_high_r <= 1'b1;
			lv_lvl_r   <= 1'b0;
			lvw_lvl_r  <= 1'b0;
			pullup_r   <= 1'b0;
		end else begin
			wait_r     <= wait_nxt;
			rdata_r    <= rdata_nxt;
			pin_ctl_r  <= pin_ctl_nxt;
			lv_ctl_r   <= lv_ctl_nxt;
			src_en_r   <= src_en_nxt;
			src_flag_r <= src_flag_nxt;
			pin_flag_r <= pin_flag_nxt;
			lv_flag_r  <= lv_flag_nxt;
			pin_high_r <= pin_high_nxt;
			lv_lvl_r   <= lv_lvl_nxt;
			lvw_lvl_r  <= lvw_lvl_nxt;
			pullup_r   <= pullup_nxt;
		end
	end

	assign avs_waitrequest_o = wait_r;
	assign avs_readdata_o    = rdata_r;
	assign pullup_en_o       = pullup_r;
	assign pin_level_o       = pin_high_r;

	// ======================================================================
	// Entry and return sequencer
	logic [2:0] cnt_r, cnt_nxt;
	logic [15:0] sp_r, sp_nxt;
	core_regs_t save_r, save_nxt;
	logic [15:0] vec_r, vec_nxt;
	logic [15:0] tgt_r, tgt_nxt;
	logic [23:0] queue_r, queue_nxt;
	core_regs_t regs_r, regs_nxt;
	mem_req_t   mem_r, mem_nxt;
	logic       done_r, done_nxt;
	logic       ret_r, ret_nxt;
	logic       busy_r, busy_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 3'h1;
		sp_nxt    = sp_r;
		save_nxt  = save_r;
		vec_nxt   = vec_r;
		tgt_nxt   = tgt_r;
		queue_nxt = queue_r;
		regs_nxt  = regs_r;
		mem_nxt   = '0;
		done_nxt  = 1'b0;
		ret_nxt   = 1'b0;
		busy_nxt  = busy_r;
		ccr_nxt   = ccr_r;
		if (ccr_wr) begin
			ccr_nxt = avs_writedata_i[7:0];
		end
		unique case (state_r)
			ST_IDLE: begin
				cnt_nxt  = 3'h0;
				save_nxt = core_i;
				sp_nxt   = core_i.sp;
				if (boundary_i) begin
					if (rti_i) begin
						state_nxt = ST_POP;
						busy_nxt  = 1'b1;
					end else if (swi_i) begin
						state_nxt = ST_PUSH;
						vec_nxt   = `VEC_SWI;
						busy_nxt  = 1'b1;
					end else if ((|pend) && !ccr_r[`CCR_I_BIT]) begin
						state_nxt = ST_PUSH;
						vec_nxt   = vec_of(prio_pick(pend));
						busy_nxt  = 1'b1;
					end
				end
			end
			ST_PUSH: begin
				// Only the low index byte is stacked; the upper byte is left to software.
				mem_nxt.req = 1'b1;
				mem_nxt.we  = 1'b1;
				mem_nxt.addr = sp_r;
				unique case (cnt_r)
					3'h0:    mem_nxt.wdata = save_r.pc[7:0];
					3'h1:    mem_nxt.wdata = save_r.pc[15:8];
					3'h2:    mem_nxt.wdata = save_r.x;
					3'h3:    mem_nxt.wdata = save_r.a;
					default: mem_nxt.wdata = ccr_r;
				endcase
				sp_nxt = sp_r - 16'h0001;
				if (cnt_r == `PUSH_LAST) begin
					state_nxt = ST_VEC;
					cnt_nxt   = 3'h0;
					ccr_nxt[`CCR_I_BIT] = 1'b1;
				end
			end
			ST_VEC: begin
				if (cnt_r < `VEC_LAST) begin
					mem_nxt.req  = 1'b1;
					mem_nxt.addr = vec_r + {13'h0, cnt_r};
				end
				if (cnt_r == 3'h1) begin
					tgt_nxt[15:8] = mem_rdata_i;
				end
				if (cnt_r == `VEC_LAST) begin
					tgt_nxt[7:0] = mem_rdata_i;
					state_nxt    = ST_FILL;
					cnt_nxt      = 3'h0;
				end
			end
			ST_FILL: begin
				if (cnt_r < `FILL_LAST) begin
					mem_nxt.req  = 1'b1;
					mem_nxt.addr = tgt_r + {13'h0, cnt_r};
				end
				if (cnt_r != 3'h0) begin
					queue_nxt = {queue_r[15:0], mem_rdata_i};
				end
				if (cnt_r == `FILL_LAST) begin
					regs_nxt.pc = tgt_r + `FILL_OFS;
					regs_nxt.sp = sp_r;
					regs_nxt.x  = save_r.x;
					regs_nxt.a  = save_r.a;
					done_nxt    = 1'b1;
					busy_nxt    = 1'b0;
					state_nxt   = ST_IDLE;
				end
			end
			ST_POP: begin
				if (cnt_r < `POP_LAST) begin
					mem_nxt.req  = 1'b1;
					mem_nxt.addr = sp_r + 16'h0001;
					sp_nxt       = sp_r + 16'h0001;
				end
				unique case (cnt_r)
					3'h1:    ccr_nxt = mem_rdata_i;
					3'h2:    regs_nxt.a = mem_rdata_i;
					3'h3:    regs_nxt.x = mem_rdata_i;
					3'h4:    regs_nxt.pc[15:8] = mem_rdata_i;
					3'h5: begin
						regs_nxt.pc[7:0] = mem_rdata_i;
						regs_nxt.sp      = sp_r;
						ret_nxt          = 1'b1;
						busy_nxt         = 1'b0;
						state_nxt        = ST_IDLE;
					end
					default: ;
				endcase
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			cnt_r   <= 3'h0;
			sp_r    <= 16'h0;
			save_r  <= '0;
			vec_r   <= 16'h0;
			tgt_r   <= 16'h0;
			queue_r <= 24'h0;
			regs_r  <= '0;
			mem_r   <= '0;
			done_r  <= 1'b0;
			ret_r   <= 1'b0;
			busy_r  <= 1'b0;
			ccr_r   <= `CCR_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			sp_r    <= sp_nxt;
			save_r  <= save_nxt;
			vec_r   <= vec_nxt;
			tgt_r   <= tgt_nxt;
			queue_r <= queue_nxt;
			regs_r  <= regs_nxt;
			mem_r   <= mem_nxt;
			done_r  <= done_nxt;
			ret_r   <= ret_nxt;
			busy_r  <= busy_nxt;
			ccr_r   <= ccr_nxt;
		end
	end

	assign mem_o      = mem_r;
	assign regs_o     = regs_r;
	assign queue_o    = queue_r;
	assign done_o     = done_r;
	assign ret_done_o = ret_r;
	assign busy_o     = busy_r;
	assign ccr_o      = ccr_r;

	// ======================================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_push_bytes;
		(mem_o.we && mem_o.wdata == save_r.pc[7:0]) ##1
		(mem_o.we && mem_o.wdata == save_r.pc[15:8]) ##1
		(mem_o.we && mem_o.wdata == save_r.x) ##1
		(mem_o.we && mem_o.wdata == save_r.a);
	endsequence

	sequence s_vec_reads;
		(!mem_o.we && mem_o.addr == vec_r) ##1 (!mem_o.we && mem_o.addr == vec_r + 16'h0001);
	endsequence

	a_push_order: assert property ((state_r == ST_PUSH && cnt_r == 3'h0) |=> s_push_bytes)
		else $error("stacking order wrong");
	a_vector_reads: assert property ((state_r == ST_VEC && cnt_r == 3'h0) |=> s_vec_reads)
		else $error("vector fetch order wrong");
	a_entry_mask: assert property ((state_r == ST_PUSH && cnt_r == `PUSH_LAST)
		|=> ccr_r[`CCR_I_BIT])
		else $error("mask not set on entry");
	a_mask_blocks: assert property ((state_r == ST_IDLE && ccr_r[`CCR_I_BIT] && !swi_i && !rti_i)
		|=> state_r == ST_IDLE)
		else $error("masked request accepted");
	a_local_enable: assert property ((state_r == ST_IDLE && pend == 6'h0 && !swi_i && !rti_i)
		|=> state_r == ST_IDLE)
		else $error("entry without enabled flag");
	a_entry_done: assert property (done_o |-> (regs_o.pc == tgt_r + `FILL_OFS) && !busy_o)
		else $error("handler address wrong");
	a_edge_hold: assert property ((pin_flag_r && !pin_ctl_r[`PIN_MODE_BIT]
		&& !(wr_go && avs_address_i == `OFS_PIN_CTRL)) |=> pin_flag_r)
		else $error("edge flag lost without ack");
	a_level_hold: assert property ((pin_ctl_r[`PIN_EN_BIT] && pin_ctl_r[`PIN_MODE_BIT]
		&& !pin_high_r) |=> pin_flag_r)
		else $error("level mode flag cleared");
	a_lv_gate: assert property ((!lv_flag_r && !(lv_ctl_r[`LV_DE_BIT] && lv_ctl_r[`LV_IE_BIT]
		&& !lv_ctl_r[`LV_RE_BIT])) |=> !lv_flag_r)
		else $error("low-voltage flag set while gated");
	a_pullup_state: assert property ($changed(pin_ctl_r) |=> pullup_en_o ==
		(pin_ctl_r[`PIN_EN_BIT] && !pin_ctl_r[`PIN_PDD_BIT]))
		else $error("pullup control wrong");
	a_return_end: assert property ((state_r == ST_POP && cnt_r == `POP_LAST)
		|=> ret_done_o ##1 !ret_done_o)
		else $error("return completion wrong");

endmodule : interrupt_sequencing_pin_irq

// ---- rtl/irq_seq_defs.svh ----
// Register offsets, field positions, reset values and sequence counts of the interrupt sequencer.
`ifndef IRQ_SEQ_DEFS_SVH
`define IRQ_SEQ_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_PIN_CTRL  8'h00
`define OFS_LV_CTRL   8'h04
`define OFS_SRC_EN    8'h08
`define OFS_SRC_FLAG  8'h0c
`define OFS_CCR       8'h10
`define OFS_STATUS    8'h14

// ==========================================================================
// Field positions
`define PIN_EN_BIT    0
`define PIN_MODE_BIT  1
`define PIN_PDD_BIT   2
`define PIN_IE_BIT    3
`define PIN_FLAG_BIT  4
`define PIN_ACK_BIT   5
`define PIN_LVL_BIT   6
`define LV_DE_BIT     0
`define LV_IE_BIT     1
`define LV_RE_BIT     2
`define LV_FLAG_BIT   3
`define LV_ACK_BIT    4
`define LV_WARN_BIT   5
`define CCR_I_BIT     3

// ==========================================================================
// Reset values
`define CCR_RST       8'h08
`define SRC_EN_RST    4'h0
`define CTRL_RST      4'h0

// ==========================================================================
// Vectors and sequence counts
`define VEC_SWI       16'hfffc
`define VEC_SRC_TOP   16'hfffa
`define PUSH_LAST     3'h4
`define VEC_LAST      3'h2
`define FILL_LAST     3'h3
`define POP_LAST      3'h5
`define FILL_OFS      16'h0003

`endif

// ---- rtl/irq_seq_pkg.sv ----
// Types shared by the interrupt sequencer and its surroundings.
package irq_seq_pkg;

	// ======================================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PUSH = 3'h1,
		ST_VEC  = 3'h3,
		ST_FILL = 3'h2,
		ST_POP  = 3'h6
	} seq_state_t;

	// ======================================================================
	// Carriers
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic [7:0]  x;
		logic [7:0]  a;
	} core_regs_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mem_req_t;

endpackage : irq_seq_pkg

// ---- tb/core_mem_model.sv ----
// Byte memory standing in for the core's bus, answering the sequencer at once.
`timescale 1ns/1ps

module core_mem_model
	import irq_seq_pkg::*;
(
	input  wire logic       clk_i,
	input  wire mem_req_t   mem_i,
	output logic      [7:0] mem_rdata_o
);
	// ======================================================================
	// Storage
	logic [7:0] mem [0:65535];
	logic [7:0] last_r;

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
		last_r = 8'h00;
	end

	// Between accesses the bus shows junk, so a late sample cannot look right.
	assign mem_rdata_o = mem_i.req ? mem[mem_i.addr] : ~last_r;

	always @(posedge clk_i) begin
		if (mem_i.req) begin
			last_r <= mem[mem_i.addr];
			if (mem_i.we) begin
				mem[mem_i.addr] <= mem_i.wdata;
			end
		end
	end
endmodule : core_mem_model

// ---- tb/interrupt_sequencing_pin_irq_tb.sv ----
// Self-checking bench for the interrupt sequencer with a memory partner.
`timescale 1ns/1ps
`include "irq_seq_defs.svh"

module interrupt_sequencing_pin_irq_tb
	import irq_seq_pkg::*;
;
	// ======================================================================
	// Signals
	logic        clk_i, rst_n_i, avs_read_i, avs_write_i, pin_irq_n_i;
	logic [7:0]  avs_address_i, mem_rdata_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [3:0]  avs_byteenable_i, periph_event_i;
	logic        avs_waitrequest_o, lv_detect_i, lv_warning_i, boundary_i, swi_i, rti_i;
	core_regs_t  core_i, regs_o;
	mem_req_t    mem_o;
	logic [23:0] queue_o;
	logic        done_o, ret_done_o, busy_o, pullup_en_o, pin_level_o;
	logic [7:0]  ccr_o, q;
	int          num_errors, n_tests, n1, n2;

	interrupt_sequencing_pin_irq u_interrupt_sequencing_pin_irq (.*);
	core_mem_model u_core_mem_model (.clk_i(clk_i), .mem_i(mem_o), .mem_rdata_o(mem_rdata_i));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// ======================================================================
	// Tasks
	task wrap_up;
		if (num_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task lost;
		num_errors++;
		wrap_up();
	endtask : lost

	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	// One Avalon access; the request stands until waitrequest is sampled low.
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		avs_address_i   <= a;
		avs_write_i     <= w;
		avs_read_i      <= !w;
		avs_writedata_i <= {24'h0, d};
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (i == 50) lost();
		q = avs_readdata_o[7:0];
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
		// One idle edge keeps the next call from re-raising a strobe in the same step.
		@(posedge clk_i);
	endtask : bus

	task rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk({24'h0, q}, {24'h0, e});
	endtask : rd

	// Instruction boundary; counts edges to the completion pulse.
	task run(input logic s, input logic r, input logic [15:0] pc_e, output int n);
		boundary_i <= 1'b1;
		swi_i      <= s;
		rti_i      <= r;
		@(posedge clk_i);
		boundary_i <= 1'b0;
		swi_i      <= 1'b0;
		rti_i      <= 1'b0;
		for (n = 1; n < 40; n++) begin
			@(posedge clk_i);
			if (done_o === 1'b1 || ret_done_o === 1'b1) break;
		end
		if (n == 40) lost();
		chk({16'h0, regs_o.pc}, {16'h0, pc_e});
	endtask : run

	task nob;
		boundary_i <= 1'b1;
		@(posedge clk_i);
		boundary_i <= 1'b0;
		cyc(2);
		chk({31'h0, busy_o}, 32'h0);
	endtask : nob

	task ev(input logic [3:0] v);
		periph_event_i <= v;
		@(posedge clk_i);
		periph_event_i <= 4'h0;
	endtask : ev

	// ======================================================================
	// Main sequence
	initial begin
		num_errors = 0;
		n_tests = 0;
		rst_n_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 8'h00;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hf;
		pin_irq_n_i = 1'b1;
		lv_detect_i = 1'b0;
		lv_warning_i = 1'b0;
		periph_event_i = 4'h0;
		boundary_i = 1'b0;
		swi_i = 1'b0;
		rti_i = 1'b0;
		core_i = '{16'h1234, 16'h00ff, 8'h56, 8'h78};
		u_core_mem_model.mem[16'hfff6] = 8'h40;
		u_core_mem_model.mem[16'hfff7] = 8'h00;
		u_core_mem_model.mem[16'h4000] = 8'ha1;
		u_core_mem_model.mem[16'h4001] = 8'ha2;
		u_core_mem_model.mem[16'h4002] = 8'ha3;
		u_core_mem_model.mem[16'hfff4] = 8'h50;
		u_core_mem_model.mem[16'hfffc] = 8'h60;
		u_core_mem_model.mem[16'hfffa] = 8'h70;
		cyc(4);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		chk({24'h0, ccr_o}, 32'h08);
		rd(`OFS_CCR, 8'h08);
		rd(8'h20, 8'h00);
		bus(1'b1, `OFS_SRC_EN, 8'h03);
		ev(4'h2);
		ev(4'h1);
		rd(`OFS_SRC_FLAG, 8'h03);
		nob();
		bus(1'b1, `OFS_CCR, 8'h00);
		cyc(4);
		chk({31'h0, busy_o}, 32'h0);
		run(1'b0, 1'b0, 16'h4003, n1);
		chk({8'h0, queue_o}, 32'ha1a2a3);
		chk({16'h0, regs_o.sp}, 32'h00fa);
		chk({24'h0, ccr_o}, 32'h08);
		for (int i = 0; i < 5; i++) begin
			q = u_core_mem_model.mem[16'h00ff - i];
			chk({24'h0, q}, {24'h0, i[2:0] == 3'h0 ? 8'h34 : i[2:0] == 3'h1 ? 8'h12 :
				i[2:0] == 3'h2 ? 8'h56 : i[2:0] == 3'h3 ? 8'h78 : 8'h00});
		end
		bus(1'b1, `OFS_SRC_FLAG, 8'h01);
		core_i <= '{16'h4003, 16'h00fa, 8'h00, 8'h00};
		run(1'b0, 1'b1, 16'h1234, n2);
		chk(n2, 7);
		chk({8'h0, regs_o.x, regs_o.a}, 32'h5678);
		cyc(1);
		chk({24'h0, ccr_o}, 32'h00);
		run(1'b0, 1'b0, 16'h5003, n2);
		bus(1'b1, `OFS_SRC_FLAG, 8'h02);
		run(1'b1, 1'b0, 16'h6003, n2);
		chk(n1, 13);
		chk(n2, n1);
		// Pin in edge mode, then level mode.
		bus(1'b1, `OFS_PIN_CTRL, 8'h01);
		cyc(1);
		chk({31'h0, pullup_en_o}, 32'h1);
		bus(1'b1, `OFS_PIN_CTRL, 8'h05);
		cyc(1);
		chk({31'h0, pullup_en_o}, 32'h0);
		pin_irq_n_i <= 1'b0;
		cyc(6);
		chk({31'h0, pin_level_o}, 32'h0);
		rd(`OFS_PIN_CTRL, 8'h15);
		pin_irq_n_i <= 1'b1;
		cyc(6);
		rd(`OFS_PIN_CTRL, 8'h55);
		bus(1'b1, `OFS_PIN_CTRL, 8'h25);
		rd(`OFS_PIN_CTRL, 8'h45);
		bus(1'b1, `OFS_PIN_CTRL, 8'h07);
		pin_irq_n_i <= 1'b0;
		cyc(6);
		bus(1'b1, `OFS_PIN_CTRL, 8'h27);
		rd(`OFS_PIN_CTRL, 8'h17);
		pin_irq_n_i <= 1'b1;
		cyc(6);
		bus(1'b1, `OFS_PIN_CTRL, 8'h27);
		rd(`OFS_PIN_CTRL, 8'h47);
		// Low voltage: reset enable blocks the flag, interrupt gate raises it.
		bus(1'b1, `OFS_CCR, 8'h00);
		bus(1'b1, `OFS_LV_CTRL, 8'h07);
		lv_detect_i <= 1'b1;
		cyc(6);
		rd(`OFS_LV_CTRL, 8'h07);
		bus(1'b1, `OFS_LV_CTRL, 8'h03);
		cyc(2);
		rd(`OFS_LV_CTRL, 8'h0b);
		run(1'b0, 1'b0, 16'h7003, n2);
		lv_detect_i <= 1'b0;
		cyc(6);
		bus(1'b1, `OFS_LV_CTRL, 8'h13);
		rd(`OFS_LV_CTRL, 8'h03);
		lv_warning_i <= 1'b1;
		bus(1'b1, `OFS_CCR, 8'h00);
		cyc(6);
		rd(`OFS_LV_CTRL, 8'h23);
		nob();
		wrap_up();
	end
endmodule : interrupt_sequencing_pin_irq_tb
